// ==== core/cfs_pkg.sv ====
// Package of constants and types for the charger fault supervisor
package cfs_pkg;

  // Register byte offsets
  localparam logic [11:0] CFS_STATUS_OFS  = 12'h000;
  localparam logic [11:0] CFS_FLAG_OFS    = 12'h004;
  localparam logic [11:0] CFS_MASK_OFS    = 12'h008;
  localparam logic [11:0] CFS_CONTROL_OFS = 12'h00c;

  // Fault indices in status, flag and mask
  localparam int CFS_NFAULT       = 13;
  localparam int CFS_F_AC1_OVP    = 0;
  localparam int CFS_F_AC2_OVP    = 1;
  localparam int CFS_F_BUS_OVP    = 2;
  localparam int CFS_F_WEAK       = 3;
  localparam int CFS_F_SYS_OVP    = 4;
  localparam int CFS_F_SYS_SHORT  = 5;
  localparam int CFS_F_BAT_OVP    = 6;
  localparam int CFS_F_BAT_OCP    = 7;
  localparam int CFS_F_IN_OCP     = 8;
  localparam int CFS_F_OTG_OUTPUT_OVERVOLTAGE    = 9;
  localparam int CFS_F_OTG_OUTPUT_UNDERVOLTAGE    = 10;
  localparam int CFS_F_THERMAL_REGULATION       = 11;
  localparam int CFS_F_THERMAL_SHUTDOWN      = 12;

  // Control register fields
  localparam int CFS_C_FITTED  = 0;
  localparam int CFS_C_BATOC   = 1;
  localparam int CFS_C_INOC    = 2;
  localparam int CFS_C_HIZ     = 3;
  localparam int CFS_C_FETDIS  = 4;
  localparam int CFS_C_OTG     = 5;
  localparam int CFS_CTRL_W    = 6;

  // Reset values
  localparam logic [CFS_CTRL_W-1:0] CFS_CONTROL_RST = 6'h00;
  localparam logic [CFS_NFAULT-1:0] CFS_MASK_RST    = 13'h0000;

  // Timing
  localparam int          CFS_TW          = 36;
  localparam longint      CFS_CLK_HZ      = 100_000_000;
  localparam longint      CFS_RETEST_S    = 420;
  localparam longint      CFS_TEST_MS     = 10;
  localparam longint      CFS_OTG_OFF_MS  = 500;
  localparam longint      CFS_INT_US      = 256;
  localparam logic [CFS_TW-1:0] CFS_RETEST_CYC  = CFS_TW'(CFS_RETEST_S * CFS_CLK_HZ);
  localparam logic [CFS_TW-1:0] CFS_TEST_CYC    = CFS_TW'((CFS_TEST_MS * CFS_CLK_HZ) / 1000);
  localparam logic [CFS_TW-1:0] CFS_OTG_OFF_CYC = CFS_TW'((CFS_OTG_OFF_MS * CFS_CLK_HZ) / 1000);
  localparam logic [CFS_TW-1:0] CFS_INT_CYC     = CFS_TW'((CFS_INT_US * CFS_CLK_HZ) / 1000000);

  // Comparator results, asynchronous to clk
  typedef struct packed {
    logic ac1_valid;
    logic ac2_valid;
    logic ac1_ovp;
    logic ac2_ovp;
    logic bus_ovp;
    logic bus_below_weak;
    logic sys_ovp;
    logic sys_in_reg;
    logic sys_short;
    logic sys_below_bat;
    logic bat_above_104;
    logic bat_above_102;
    logic bat_ocp;
    logic input_ocp;
    logic otg_above_rise;
    logic otg_above_fall;
    logic otg_below_uvp;
    logic thermal_regulation;
    logic thermal_shutdown_trip;
    logic thermal_shutdown_above_release;
    logic adapter_present;
  } cfs_cmp_t;

  // Power stage controls
  typedef struct packed {
    logic converter_enable;
    logic current_limit_low;
    logic ac1_fet_on;
    logic ac2_fet_on;
    logic battery_switch_on;
    logic ship_switch_on;
    logic test_load_on;
    logic charge_current_reduce;
    logic termination_disable;
    logic safety_timer_half_rate;
  } cfs_drv_t;

  typedef enum logic [1:0] {CFS_SRC_TEST, CFS_SRC_GOOD, CFS_SRC_WAIT} cfs_src_t;

endpackage

// ==== core/cfs_supervisor.sv ====
// Charger fault supervisor with AHB-Lite register slave
//
// Decided for this implementation: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module cfs_supervisor #(
  parameter logic [cfs_pkg::CFS_TW-1:0] RETEST_CYC  = cfs_pkg::CFS_RETEST_CYC,
  parameter logic [cfs_pkg::CFS_TW-1:0] TEST_CYC    = cfs_pkg::CFS_TEST_CYC,
  parameter logic [cfs_pkg::CFS_TW-1:0] OTG_OFF_CYC = cfs_pkg::CFS_OTG_OFF_CYC,
  parameter logic [cfs_pkg::CFS_TW-1:0] INT_CYC     = cfs_pkg::CFS_INT_CYC
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // AHB-Lite slave
  input  wire logic             hsel,
  input  wire logic [11:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic             hready,
  input  wire logic [31:0]      hwdata,
  output logic [31:0]           hrdata,
  output logic                  hreadyout,
  output logic                  hresp,
  // Comparators and converter timing
  input  wire cfs_pkg::cfs_cmp_t cmp_async,
  input  wire logic             sw_cycle_tick,
  input  wire logic             run_request,
  // Power stage and host interrupt
  output cfs_pkg::cfs_drv_t     drv,
  output logic                  int_n
);
  import cfs_pkg::*;

  localparam int NCMP = $bits(cfs_cmp_t);

  // Two-stage synchroniser
  logic [NCMP-1:0] meta_q;
  logic [NCMP-1:0] sync_q;
  cfs_cmp_t        c;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= cmp_async;
      sync_q <= meta_q;
    end
  end
  assign c = cfs_cmp_t'(sync_q);

  // Bus address phase
  logic        addr_ok;
  logic        wr_pend_q;
  logic [11:0] wr_addr_q;
  logic        rd_now;
  logic        rd_flag;
  logic        wr_mask;
  logic        wr_ctrl;

  assign addr_ok  = hsel && htrans[1] && hready;
  assign rd_now   = addr_ok && !hwrite;
  assign rd_flag  = rd_now && (haddr == CFS_FLAG_OFS);
  assign wr_mask  = wr_pend_q && (wr_addr_q == CFS_MASK_OFS);
  assign wr_ctrl  = wr_pend_q && (wr_addr_q == CFS_CONTROL_OFS);

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Registers
  logic [CFS_NFAULT-1:0] mask_q;
  logic [CFS_NFAULT-1:0] flag_q;
  logic [CFS_NFAULT-1:0] flag_d;
  logic [CFS_NFAULT-1:0] status;
  logic [CFS_NFAULT-1:0] status_q;
  logic [CFS_NFAULT-1:0] rise;
  logic [CFS_CTRL_W-1:0] ctrl_q;
  logic [CFS_CTRL_W-1:0] ctrl_d;

  // Fault latches with hysteresis
  logic sys_ovp_q;
  logic bat_ovp_q;
  logic thermal_shutdown_q;
  logic otg_output_overvoltage_q;
  logic adapter_q;
  logic reattach;

  logic otg_mode;
  logic fwd_charge;
  logic in_ocp_trip;

  assign otg_mode    = ctrl_q[CFS_C_OTG];
  assign fwd_charge  = c.adapter_present && !otg_mode;
  assign in_ocp_trip = ctrl_q[CFS_C_INOC] && fwd_charge && c.input_ocp;
  assign reattach    = c.adapter_present && !adapter_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sys_ovp_q <= 1'b0;
      bat_ovp_q <= 1'b0;
      thermal_shutdown_q   <= 1'b0;
      otg_output_overvoltage_q <= 1'b0;
      adapter_q <= 1'b0;
    end else begin
      adapter_q <= c.adapter_present;
      // Hold until back at regulation
      if (c.sys_ovp)
        sys_ovp_q <= 1'b1;
      else if (c.sys_in_reg)
        sys_ovp_q <= 1'b0;
      // 104% trips, 102% releases
      if (c.bat_above_104)
        bat_ovp_q <= 1'b1;
      else if (!c.bat_above_102)
        bat_ovp_q <= 1'b0;
      // Release only past the hysteresis
      if (c.thermal_shutdown_trip)
        thermal_shutdown_q <= 1'b1;
      else if (!c.thermal_shutdown_above_release)
        thermal_shutdown_q <= 1'b0;
      // Acts on the next switching cycle
      if (!otg_mode || !c.otg_above_fall)
        otg_output_overvoltage_q <= 1'b0;
      else if (sw_cycle_tick && c.otg_above_rise)
        otg_output_overvoltage_q <= 1'b1;
    end
  end

  // Weak-source test sequencer
  cfs_src_t          src_q;
  cfs_src_t          src_d;
  logic [CFS_TW-1:0] src_cnt_q;
  logic [CFS_TW-1:0] src_cnt_d;
  logic              weak_q;
  logic              weak_d;
  logic              src_done;

  assign src_done = (src_cnt_q == '0);

  always_comb begin
    src_d     = src_q;
    src_cnt_d = src_done ? src_cnt_q : src_cnt_q - 1'b1;
    weak_d    = weak_q;
    case (src_q)
      CFS_SRC_TEST: begin
        if (src_done) begin
          weak_d = c.bus_below_weak;
          if (c.bus_below_weak) begin
            src_d     = CFS_SRC_WAIT;
            src_cnt_d = RETEST_CYC;
          end else begin
            src_d = CFS_SRC_GOOD;
          end
        end
      end
      CFS_SRC_WAIT: begin
        if (src_done) begin
          src_d     = CFS_SRC_TEST;
          src_cnt_d = TEST_CYC;
        end
      end
      default: begin
        // New adapter gets a fresh test
        if (reattach) begin
          src_d     = CFS_SRC_TEST;
          src_cnt_d = TEST_CYC;
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      src_q     <= CFS_SRC_TEST;
      src_cnt_q <= TEST_CYC;
      weak_q    <= 1'b0;
    end else begin
      src_q     <= src_d;
      src_cnt_q <= src_cnt_d;
      weak_q    <= weak_d;
    end
  end

  // OTG under-voltage retry
  logic              otg_off_q;
  logic [CFS_TW-1:0] otg_cnt_q;
  logic              otg_trip;
  logic              conv_on;

  assign otg_trip = otg_mode && drv.converter_enable && c.otg_below_uvp && !otg_off_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      otg_off_q <= 1'b0;
      otg_cnt_q <= '0;
    end else if (otg_trip) begin
      otg_off_q <= 1'b1;
      otg_cnt_q <= OTG_OFF_CYC;
    end else if (otg_off_q) begin
      if (otg_cnt_q == '0)
        otg_off_q <= 1'b0;
      else
        otg_cnt_q <= otg_cnt_q - 1'b1;
    end
  end

  // Live status; held faults read from their latches
  always_comb begin
    status                  = '0;
    status[CFS_F_AC1_OVP]   = c.ac1_ovp;
    status[CFS_F_AC2_OVP]   = c.ac2_ovp;
    status[CFS_F_BUS_OVP]   = c.bus_ovp;
    status[CFS_F_WEAK]      = weak_q;
    status[CFS_F_SYS_OVP]   = sys_ovp_q;
    status[CFS_F_SYS_SHORT] = c.sys_short;
    status[CFS_F_BAT_OVP]   = bat_ovp_q;
    status[CFS_F_BAT_OCP]   = c.bat_ocp;
    status[CFS_F_IN_OCP]    = c.input_ocp;
    status[CFS_F_OTG_OUTPUT_OVERVOLTAGE]   = otg_output_overvoltage_q;
    status[CFS_F_OTG_OUTPUT_UNDERVOLTAGE]   = otg_off_q;
    status[CFS_F_THERMAL_REGULATION]      = c.thermal_regulation;
    status[CFS_F_THERMAL_SHUTDOWN]     = thermal_shutdown_q;
  end

  assign rise = status & ~status_q;

  // Set wins over clear-on-read
  assign flag_d = (rd_flag ? '0 : flag_q) | rise;

  // Hardware set of the shutdown bits wins over host writes and reattach
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ctrl)
      ctrl_d = hwdata[CFS_CTRL_W-1:0];
    if (reattach) begin
      ctrl_d[CFS_C_HIZ]    = 1'b0;
      ctrl_d[CFS_C_FETDIS] = 1'b0;
    end
    if (in_ocp_trip) begin
      ctrl_d[CFS_C_HIZ]    = 1'b1;
      ctrl_d[CFS_C_FETDIS] = 1'b1;
    end
  end

  // Read mux
  logic [31:0] rd_data;
  assign rd_data = (haddr == CFS_STATUS_OFS)  ? 32'(status) :
                   (haddr == CFS_FLAG_OFS)    ? 32'(flag_q) :
                   (haddr == CFS_MASK_OFS)    ? 32'(mask_q) :
                   (haddr == CFS_CONTROL_OFS) ? 32'(ctrl_q) : 32'h0000_0000;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 12'h000;
      hrdata    <= 32'h0000_0000;
      mask_q    <= CFS_MASK_RST;
      flag_q    <= '0;
      status_q  <= '0;
      ctrl_q    <= CFS_CONTROL_RST;
    end else begin
      wr_pend_q <= addr_ok && hwrite;
      wr_addr_q <= haddr;
      if (rd_now)
        hrdata <= rd_data;
      if (wr_mask)
        mask_q <= hwdata[CFS_NFAULT-1:0];
      flag_q   <= flag_d;
      status_q <= status;
      ctrl_q   <= ctrl_d;
    end
  end

  // Interrupt pulse; events during a pulse do not stretch it
  logic              int_q;
  logic [CFS_TW-1:0] int_cnt_q;
  logic              int_event;

  assign int_event = |(rise & ~mask_q);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      int_q     <= 1'b0;
      int_cnt_q <= '0;
    end else if (!int_q && int_event) begin
      int_q     <= 1'b1;
      int_cnt_q <= INT_CYC - 1'b1;
    end else if (int_q) begin
      if (int_cnt_q == '0)
        int_q <= 1'b0;
      else
        int_cnt_q <= int_cnt_q - 1'b1;
    end
  end
  assign int_n = !int_q;

  // Power stage decisions
  logic     ac1_ok;
  logic     ac2_ok;
  logic     use_ac1;
  logic     ship_open;
  cfs_drv_t drv_d;

  assign ac1_ok    = c.ac1_valid && !c.ac1_ovp;
  assign ac2_ok    = c.ac2_valid && !c.ac2_ovp;
  assign use_ac1   = ac1_ok;
  assign ship_open = c.bat_ocp && ctrl_q[CFS_C_FITTED] && ctrl_q[CFS_C_BATOC];

  // Any stopping fault overrides the run request
  assign conv_on = run_request
                && !c.bus_ovp
                && !(src_q == CFS_SRC_TEST) && !weak_q
                && !sys_ovp_q
                && !bat_ovp_q
                && !ctrl_q[CFS_C_HIZ]
                && !thermal_shutdown_q
                && !otg_output_overvoltage_q
                && !otg_off_q;

  always_comb begin
    drv_d                        = '0;
    drv_d.converter_enable       = conv_on;
    drv_d.current_limit_low      = c.sys_short;
    drv_d.ac1_fet_on             = use_ac1 && !ctrl_q[CFS_C_FETDIS];
    drv_d.ac2_fet_on             = !use_ac1 && ac2_ok && !ctrl_q[CFS_C_FETDIS];
    drv_d.battery_switch_on      = c.sys_below_bat;
    drv_d.ship_switch_on         = !ship_open;
    drv_d.test_load_on           = (src_q == CFS_SRC_TEST);
    drv_d.charge_current_reduce  = c.thermal_regulation;
    drv_d.termination_disable    = c.thermal_regulation;
    drv_d.safety_timer_half_rate = c.thermal_regulation;
  end

  // Registered so the pins never glitch on comparator races
  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      drv <= '0;
    else
      drv <= drv_d;
  end

endmodule

`default_nettype wire

// ==== verif/cfs_supervisor_chk.sv ====
// Checker of the supervisor's port behaviour
`timescale 1ns/1ps
`default_nettype none
module cfs_supervisor_chk #(
  parameter logic [cfs_pkg::CFS_TW-1:0] INT_CYC = cfs_pkg::CFS_INT_CYC
) (
  // Clock and reset
  input wire logic              clk,
  input wire logic              reset,
  // Comparators and power stage
  input wire cfs_pkg::cfs_cmp_t cmp_async,
  input wire cfs_pkg::cfs_drv_t drv,
  // Host interrupt
  input wire logic              int_n
);
  import cfs_pkg::*;
  logic [CFS_TW-1:0] low_cnt_q;
  // Pulse length counted here; a repetition of that length would be too slow
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      low_cnt_q <= '0;
    end else if (!int_n) begin
      low_cnt_q <= low_cnt_q + 1'b1;
    end else begin
      low_cnt_q <= '0;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Five samples cover the synchroniser and output register
  a_bus_ovp_off: assert property (cmp_async.bus_ovp [*5] |-> !drv.converter_enable)
    else $error("converter on during bus over-voltage");
  a_sys_ovp_off: assert property (cmp_async.sys_ovp [*5] |-> !drv.converter_enable)
    else $error("converter on during system over-voltage");
  a_bat_ovp_off: assert property (cmp_async.bat_above_104 [*5] |-> !drv.converter_enable)
    else $error("converter on above battery limit");
  a_thermal_shutdown_off: assert property (cmp_async.thermal_shutdown_trip [*5] |-> !drv.converter_enable)
    else $error("converter on during thermal shutdown");
  a_ac_fet_off: assert property (cmp_async.ac1_ovp [*5] |-> !drv.ac1_fet_on)
    else $error("first input fets on during over-voltage");
  a_one_pair: assert property (!(drv.ac1_fet_on && drv.ac2_fet_on))
    else $error("both input fet pairs on");
  a_short_limit: assert property (cmp_async.sys_short [*5] |-> drv.current_limit_low)
    else $error("no current limit on system short");
  a_thermal_regulation_act: assert property (cmp_async.thermal_regulation [*5] |->
    drv.charge_current_reduce && drv.termination_disable && drv.safety_timer_half_rate)
    else $error("thermal regulation actions missing");
  a_batsw_on: assert property (cmp_async.sys_below_bat [*5] |-> drv.battery_switch_on)
    else $error("battery switch off with system below battery");
  a_int_width: assert property ($rose(int_n) |-> low_cnt_q == INT_CYC)
    else $error("interrupt pulse of wrong length");
  c_int: cover property ($fell(int_n));
  c_conv_off: cover property ($fell(drv.converter_enable));
  c_ship_open: cover property ($fell(drv.ship_switch_on));
  c_retest: cover property ($rose(drv.test_load_on));
endmodule
bind cfs_supervisor cfs_supervisor_chk #(.INT_CYC(INT_CYC)) u_cfs_supervisor_chk (
  .clk(clk), .reset(reset), .cmp_async(cmp_async), .drv(drv), .int_n(int_n));
`default_nettype wire

// ==== verif/cfs_host_model.sv ====
// Host side model that watches the interrupt line
`timescale 1ns/1ps
`default_nettype none
module cfs_host_model (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Interrupt from the supervisor
  input wire logic int_n,
  // Pulse count and last pulse length
  output var int   pulses,
  output var int   width
);
  int run_q;
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      run_q <= 0;
      pulses <= 0;
      width <= 0;
    end else if (!int_n) begin
      run_q <= run_q + 1;
    end else if (run_q > 0) begin
      width <= run_q;
      pulses <= pulses + 1;
      run_q <= 0;
    end
  end
endmodule
`default_nettype wire

// ==== verif/testbench.sv ====
// Self-checking testbench of the charger fault supervisor
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import cfs_pkg::*;
  // Short counts keep the run brief
  localparam logic [CFS_TW-1:0] RT = 36'h0c8;
  localparam logic [CFS_TW-1:0] TT = 36'h014;
  localparam logic [CFS_TW-1:0] OT = 36'h032;
  localparam logic [CFS_TW-1:0] IT = 36'h010;
  logic        clk, reset, hsel, hwrite, sw_cycle_tick, run_request, hreadyout, hresp, int_n;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize, tick_q;
  logic [31:0] hwdata, hrdata, rd;
  cfs_cmp_t    cmp;
  cfs_drv_t    drv;
  int          n_errors, checked, pulses, width, p0;
  time         t0;
  int          fidx [4] = '{CFS_F_BUS_OVP, CFS_F_SYS_OVP, CFS_F_BAT_OVP, CFS_F_THERMAL_SHUTDOWN};
  cfs_supervisor #(.RETEST_CYC(RT), .TEST_CYC(TT), .OTG_OFF_CYC(OT), .INT_CYC(IT)) u_cfs_supervisor (
    .clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .cmp_async(cmp), .sw_cycle_tick(sw_cycle_tick), .run_request(run_request), .drv(drv), .int_n(int_n));
  cfs_host_model u_cfs_host_model (.clk(clk), .reset(reset), .int_n(int_n), .pulses(pulses), .width(width));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    tick_q <= tick_q + 3'h1;
    sw_cycle_tick <= (tick_q == 3'h0);
  end
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask
  task automatic chk_w(input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %0t: word %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_b(input logic e, input logic g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %0t: bit %b expected %b", $time, g, e);
    end
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    chk_w(e, rd);
  endtask
  task automatic st_chk(input int i, input logic e);
    bus(CFS_STATUS_OFS, 1'b0, 32'h0);
    chk_b(e, rd[i]);
  endtask
  task automatic set_fault(input int i, input logic v);
    case (i)
      0: begin
        cmp.bus_ovp <= v;
        cmp.sys_below_bat <= v;
      end
      1: begin
        cmp.sys_ovp <= v;
        cmp.sys_in_reg <= !v;
      end
      2: begin
        cmp.bat_above_104 <= v;
        cmp.bat_above_102 <= v;
      end
      default: begin
        cmp.thermal_shutdown_trip <= v;
        cmp.thermal_shutdown_above_release <= v || cmp.thermal_shutdown_above_release;
      end
    endcase
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    n_errors++;
    $display("BAD %0t: watchdog ran out", $time);
    end_of_test();
  end
  initial begin
    reset = 1'b1;
    {hsel, hwrite, htrans, haddr, hwdata, tick_q, sw_cycle_tick} = '0;
    hsize = 3'h2;
    run_request = 1'b1;
    cmp = '0;
    {cmp.ac1_valid, cmp.ac2_valid, cmp.adapter_present, cmp.bus_below_weak} = 4'hf;
    wait_n(4);
    reset <= 1'b0;
    wait_n(2);
    chk_b(1'b1, drv.test_load_on);
    rd_chk(CFS_MASK_OFS, 32'h0);
    rd_chk(CFS_CONTROL_OFS, 32'h0);
    bus(12'h010, 1'b1, 32'hffffffff);
    rd_chk(12'h010, 32'h0);
    chk_b(1'b0, hresp);
    while (drv.test_load_on !== 1'b0) @(posedge clk);
    t0 = $time;
    chk_b(1'b0, drv.converter_enable);
    st_chk(CFS_F_WEAK, 1'b1);
    cmp.bus_below_weak <= 1'b0;
    wait_n(25);
    chk_w(32'h1, 32'(pulses));
    chk_w(32'(IT), 32'(width));
    rd_chk(CFS_FLAG_OFS, 32'h1 << CFS_F_WEAK);
    rd_chk(CFS_FLAG_OFS, 32'h0);
    while (drv.test_load_on !== 1'b1) @(posedge clk);
    chk_b(1'b1, ($time - t0) / 10 >= RT && ($time - t0) / 10 <= RT + 3);
    wait_n(TT + 8);
    chk_b(1'b1, drv.converter_enable);
    $display("test weak source done");
    for (int i = 0; i < 4; i++) begin
      bus(CFS_MASK_OFS, 1'b1, (i == 1) ? 32'h1 << CFS_F_SYS_OVP : 32'h0);
      p0 = pulses;
      set_fault(i, 1'b1);
      wait_n(8);
      chk_b(1'b0, drv.converter_enable);
      if (i == 0) chk_b(1'b1, drv.battery_switch_on);
      st_chk(fidx[i], 1'b1);
      set_fault(i, 1'b0);
      wait_n(8);
      if (i == 0) chk_b(1'b0, drv.battery_switch_on);
      if (i == 3) begin
        chk_b(1'b0, drv.converter_enable);
        cmp.thermal_shutdown_above_release <= 1'b0;
        wait_n(8);
      end
      chk_b(1'b1, drv.converter_enable);
      wait_n(20);
      chk_w((i == 1) ? 32'h0 : 32'h1, 32'(pulses - p0));
      rd_chk(CFS_FLAG_OFS, 32'h1 << fidx[i]);
    end
    $display("test converter faults done");
    cmp.ac1_ovp <= 1'b1;
    wait_n(8);
    chk_b(1'b0, drv.ac1_fet_on);
    chk_b(1'b1, drv.ac2_fet_on);
    st_chk(CFS_F_AC1_OVP, 1'b1);
    cmp.ac1_ovp <= 1'b0;
    wait_n(30);
    chk_b(1'b1, drv.ac1_fet_on);
    bus(CFS_CONTROL_OFS, 1'b1, 32'h1);
    p0 = pulses;
    for (int k = 0; k < 2; k++) begin
      cmp.bat_ocp <= 1'b1;
      wait_n(8);
      chk_b(k == 0, drv.ship_switch_on);
      st_chk(CFS_F_BAT_OCP, 1'b1);
      cmp.bat_ocp <= 1'b0;
      wait_n(30);
      chk_b(1'b1, drv.ship_switch_on);
      bus(CFS_CONTROL_OFS, 1'b1, 32'h3);
    end
    chk_w(32'h2, 32'(pulses - p0));
    $display("test input and ship switches done");
    bus(CFS_CONTROL_OFS, 1'b1, 32'h0);
    cmp.input_ocp <= 1'b1;
    wait_n(8);
    rd_chk(CFS_CONTROL_OFS, 32'h0);
    st_chk(CFS_F_IN_OCP, 1'b1);
    chk_b(1'b1, drv.converter_enable);
    cmp.input_ocp <= 1'b0;
    bus(CFS_CONTROL_OFS, 1'b1, 32'h4);
    for (int k = 0; k < 2; k++) begin
      cmp.input_ocp <= 1'b1;
      wait_n(8);
      cmp.input_ocp <= 1'b0;
      rd_chk(CFS_CONTROL_OFS, 32'h1c);
      chk_b(1'b0, drv.converter_enable);
      chk_b(1'b0, drv.ac1_fet_on || drv.ac2_fet_on);
      if (k == 0) bus(CFS_CONTROL_OFS, 1'b1, 32'h4);
      cmp.adapter_present <= (k == 0);
      wait_n(8);
      cmp.adapter_present <= 1'b1;
      wait_n(TT + 12);
      rd_chk(CFS_CONTROL_OFS, 32'h4);
      chk_b(1'b1, drv.converter_enable);
    end
    $display("test input over-current done");
    {cmp.sys_short, cmp.thermal_regulation} <= 2'h3;
    wait_n(8);
    chk_b(1'b1, drv.current_limit_low);
    chk_b(1'b1, drv.charge_current_reduce && drv.termination_disable && drv.safety_timer_half_rate);
    st_chk(CFS_F_SYS_SHORT, 1'b1);
    st_chk(CFS_F_THERMAL_REGULATION, 1'b1);
    {cmp.sys_short, cmp.thermal_regulation} <= 2'h0;
    bus(CFS_CONTROL_OFS, 1'b1, 32'h20);
    bus(CFS_FLAG_OFS, 1'b0, 32'h0);
    cmp.otg_below_uvp <= 1'b1;
    wait_n(8);
    cmp.otg_below_uvp <= 1'b0;
    wait_n(OT / 2);
    chk_b(1'b0, drv.converter_enable);
    wait_n(OT);
    chk_b(1'b1, drv.converter_enable);
    rd_chk(CFS_FLAG_OFS, 32'h1 << CFS_F_OTG_OUTPUT_UNDERVOLTAGE);
    {cmp.otg_above_rise, cmp.otg_above_fall} <= 2'h3;
    wait_n(20);
    cmp.otg_above_rise <= 1'b0;
    wait_n(20);
    chk_b(1'b0, drv.converter_enable);
    cmp.otg_above_fall <= 1'b0;
    wait_n(20);
    chk_b(1'b1, drv.converter_enable);
    $display("test thermal and output mode done");
    end_of_test();
  end
endmodule
`default_nettype wire
